/* rtl/huep_map.vh */
`ifndef HUEP_MAP_VH
`define HUEP_MAP_VH

// device mode codes on the mode select input
`define HUEP_MODE_PORT 1'h0
`define HUEP_MODE_HOST 1'h1

// host side widths
`define HUEP_DATA_W 8
`define HUEP_ADDR_W 3
`define HUEP_NUM_REGS 8

// write queue shape: address field above data field
`define HUEP_WQ_W 11
`define HUEP_WQ_DEPTH 8
`define HUEP_WQ_DATA_LSB 0
`define HUEP_WQ_DATA_MSB 7
`define HUEP_WQ_ADDR_LSB 8
`define HUEP_WQ_ADDR_MSB 10

// reset and idle levels of the shared pins
`define HUEP_BYTE_ZERO 8'h00
`define HUEP_OEN_OFF 8'hFF
`define HUEP_OEN_ON 8'h00
`define HUEP_ADDR_ZERO 3'h0
// select, write and read strobes all idle high
`define HUEP_STRB_IDLE 3'h7
`define HUEP_WQ_ZERO 11'h000
`define HUEP_LOW 1'h0
`define HUEP_HIGH 1'h1

`endif

/* rtl/huep_fifo.v */
`timescale 1ns/1ps
`default_nettype none
// small synchronous fifo, one clock, full and empty decoded from a registered count
module huep_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rstn,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset needed
  reg [AW-1:0] wrPtr_reg; // next slot to fill
  reg [AW-1:0] rdPtr_reg; // oldest slot
  reg [AW:0] count_reg; // words held
  wire push; // accepted write
  wire pop; // accepted read

  assign inReady = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_reg];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // storage write, no reset keeps it a plain ram
  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/huep_port.v */
// Function
// - mode 1: data pins carry host bytes
// - mode 0: data pins become port A
// - driver disable low during host reads
// - three select bits pick emulated register
// - act only while host select low
// - write strobe low marks register write
// - read strobe low drives selected register
// - host irq high while interrupt pending
// - tx ready low while holding empty, only in dma mode
// - rx ready low while byte waiting, only in dma mode
// - select pins shared with serial B
// - strobe pins revert to serial B
// - status outputs yield pins in mode 0
`timescale 1ns/1ps
`include "huep_map.vh"
`default_nettype none
module huep_port #(
  parameter WQ_DEPTH = `HUEP_WQ_DEPTH,
  parameter WQ_AW = 3
) (
  input wire clk,
  input wire rstn,
  input wire hostMode,
  input wire serialAltSel,
  input wire [7:0] host_data_bus_in,
  output reg [7:0] host_data_bus_out,
  output reg [7:0] host_data_bus_oen_n,
  input wire [2:0] host_reg_select,
  input wire host_select_n,
  input wire host_write_n,
  input wire host_read_n,
  output reg host_driver_disable_n,
  output reg host_irq,
  output reg host_tx_ready_n,
  output reg host_rx_ready_n,
  input wire [7:0] portAOut,
  input wire [7:0] portADir,
  output reg [7:0] port_a_pins,
  output reg serial_b_txrx_clock,
  output reg serial_b_rx_data,
  output reg serial_b_rxtx_clock,
  output reg serial_b_sync,
  output reg serial_b_clear_to_send,
  output reg serial_b_carrier_detect,
  input wire serial_b_tx_data,
  input wire serial_b_terminal_ready_request,
  input wire serial_b_wait_request,
  input wire serial_b_request_to_send,
  input wire clocked_serial_tx,
  input wire clocked_serial_clock,
  input wire dma1_transfer_end_n,
  input wire coreRegWe,
  input wire [2:0] coreRegAddr,
  input wire [7:0] coreRegData,
  input wire coreIrqPending,
  input wire coreDmaMode,
  input wire coreThrEmpty,
  input wire coreRxAvail,
  output reg coreWrValid,
  input wire coreWrReady,
  output reg [2:0] coreWrAddr,
  output reg [7:0] coreWrData,
  output reg coreRdPulse,
  output reg [2:0] coreRdAddr,
  output reg hostWrFull,
  output reg hostWrOverrun
);
  // two-flop synchronisers for every pin input
  reg [7:0] dataMeta_reg; // first stage, read only by second
  reg [7:0] dataSync_reg; // host data, safe to use
  reg [2:0] addrMeta_reg; // first stage of select bits
  reg [2:0] addrSync_reg; // synced select bits or serial pins
  reg [2:0] strbMeta_reg; // first stage of select, write, read
  reg [2:0] strbSync_reg; // {select_n, write_n, read_n}
  reg [2:0] strbPrev_reg; // one cycle older, for edges
  reg [7:0] dataPrev_reg; // data held the cycle before the rise
  reg [2:0] addrPrev_reg; // address held the cycle before the rise
  // images have no reset; the core must fill all before host reads
  reg [7:0] shadow [0:`HUEP_NUM_REGS-1]; // emulated register images
  reg readActive_reg; // host read in progress
  wire selN; // synced select
  wire wrN; // synced write strobe
  wire rdN; // synced read strobe
  wire hostOn; // host function owns the pins
  wire readNow; // read window open now
  wire writeRise; // end of a host write
  wire wqInReady; // queue can take a word
  wire wqOutValid; // queue holds a word
  wire wqPop; // move head into output stage
  wire [`HUEP_WQ_W-1:0] wqOutData; // queue head
  wire [`HUEP_WQ_W-1:0] wqInData; // captured address and data

  assign selN = strbSync_reg[2];
  assign wrN = strbSync_reg[1];
  assign rdN = strbSync_reg[0];
  // mode 0 hands every shared pin back to its other owner
  assign hostOn = (hostMode == `HUEP_MODE_HOST);
  // device joins only while selected
  assign readNow = hostOn & ~selN & ~rdN;
  // data and address come from the history stage, so a host that
  // lets go of the data together with the strobe still lands its byte
  // rise of write while select was low, data from before
  assign writeRise = hostOn & wrN & ~strbPrev_reg[1] & ~strbPrev_reg[2];
  assign wqInData = {addrPrev_reg, dataPrev_reg};
  // output stage refills when empty or when the core takes it
  // one word waits in the stage, so nine writes fit before a drop
  assign wqPop = wqOutValid & (~coreWrValid | coreWrReady);

  // synchroniser chain and edge history
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataMeta_reg <= `HUEP_BYTE_ZERO;
      dataSync_reg <= `HUEP_BYTE_ZERO;
      addrMeta_reg <= `HUEP_ADDR_ZERO;
      addrSync_reg <= `HUEP_ADDR_ZERO;
      // idle high, so no false write edge follows reset
      strbMeta_reg <= `HUEP_STRB_IDLE;
      strbSync_reg <= `HUEP_STRB_IDLE;
      strbPrev_reg <= `HUEP_STRB_IDLE;
      dataPrev_reg <= `HUEP_BYTE_ZERO;
      addrPrev_reg <= `HUEP_ADDR_ZERO;
    end else begin
      dataMeta_reg <= host_data_bus_in;
      dataSync_reg <= dataMeta_reg;
      addrMeta_reg <= host_reg_select;
      addrSync_reg <= addrMeta_reg;
      strbMeta_reg <= {host_select_n, host_write_n, host_read_n};
      strbSync_reg <= strbMeta_reg;
      strbPrev_reg <= strbSync_reg;
      dataPrev_reg <= dataSync_reg;
      addrPrev_reg <= addrSync_reg;
    end
  end

  // register images kept for host reads; core owns their contents
  always @(posedge clk) begin
    if (coreRegWe) begin
      shadow[coreRegAddr] <= coreRegData;
    end
  end

  // host writes queue here so a slow core does not lose bytes
  // depth is a trade: short bursts ride out a busy core, longer
  // ones drop bytes and the overrun flag reports it
  huep_fifo #(
    .WIDTH(`HUEP_WQ_W),
    .DEPTH(WQ_DEPTH),
    .AW(WQ_AW)
  ) huep_fifo_inst (
    .clk(clk),
    .rstn(rstn),
    .inValid(writeRise),
    .inReady(wqInReady),
    .inData(wqInData),
    .outValid(wqOutValid),
    .outReady(wqPop),
    .outData(wqOutData)
  );

  // registered output stage toward the core
  // a presented word stays put until the core takes it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coreWrValid <= `HUEP_LOW;
      coreWrAddr <= `HUEP_ADDR_ZERO;
      coreWrData <= `HUEP_BYTE_ZERO;
    end else begin
      if (wqPop) begin
        // head becomes the presented write
        coreWrValid <= `HUEP_HIGH;
        coreWrAddr <= wqOutData[`HUEP_WQ_ADDR_MSB:`HUEP_WQ_ADDR_LSB];
        coreWrData <= wqOutData[`HUEP_WQ_DATA_MSB:`HUEP_WQ_DATA_LSB];
      end else if (coreWrReady) begin
        // taken and nothing behind it
        coreWrValid <= `HUEP_LOW;
      end
    end
  end

  // queue status; host bus has no wait pin, so a full queue drops
  // full lags the queue count by one clock
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hostWrFull <= `HUEP_LOW;
      hostWrOverrun <= `HUEP_LOW;
    end else begin
      hostWrFull <= ~wqInReady;
      // sticky until mode leaves host function
      if (writeRise && !wqInReady) begin
        hostWrOverrun <= `HUEP_HIGH;
      end else if (!hostOn) begin
        hostWrOverrun <= `HUEP_LOW;
      end
    end
  end

  // read tracking and one pulse per read to the core
  // one pulse however long the host keeps the strobe low
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readActive_reg <= `HUEP_LOW;
      coreRdPulse <= `HUEP_LOW;
      coreRdAddr <= `HUEP_ADDR_ZERO;
    end else begin
      readActive_reg <= readNow;
      // start of a read lets the core pop its receive byte
      coreRdPulse <= readNow & ~readActive_reg;
      if (readNow && !readActive_reg) begin
        coreRdAddr <= addrSync_reg;
      end
    end
  end

  // data pins: host bus in mode 1, port A in mode 0
  // drive is registered behind the synchronisers, so the bus turns
  // on three clocks after the strobe falls and off three after it rises
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_data_bus_out <= `HUEP_BYTE_ZERO;
      host_data_bus_oen_n <= `HUEP_OEN_OFF;
      port_a_pins <= `HUEP_BYTE_ZERO;
    end else begin
      if (hostOn) begin
        port_a_pins <= `HUEP_BYTE_ZERO;
        if (readNow) begin
          // selected image driven while read and select low
          host_data_bus_out <= shadow[addrSync_reg];
          host_data_bus_oen_n <= `HUEP_OEN_ON;
        end else begin
          // bus released between reads
          host_data_bus_out <= `HUEP_BYTE_ZERO;
          host_data_bus_oen_n <= `HUEP_OEN_OFF;
        end
      end else begin
        // per-bit direction, low enable drives the pin
        host_data_bus_out <= portAOut;
        host_data_bus_oen_n <= ~portADir;
        port_a_pins <= dataSync_reg;
      end
    end
  end

  // inputs of shared pins handed to serial B in mode 0
  // levels only; the serial clock pins are inputs in this block
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_b_txrx_clock <= `HUEP_LOW;
      serial_b_rx_data <= `HUEP_LOW;
      serial_b_rxtx_clock <= `HUEP_LOW;
      serial_b_sync <= `HUEP_HIGH;
      serial_b_clear_to_send <= `HUEP_HIGH;
      serial_b_carrier_detect <= `HUEP_HIGH;
    end else begin
      if (hostOn) begin
        // pins belong to the host; serial side sees idle
        // idle levels keep the serial receiver quiet
        serial_b_txrx_clock <= `HUEP_LOW;
        serial_b_rx_data <= `HUEP_LOW;
        serial_b_rxtx_clock <= `HUEP_LOW;
        serial_b_sync <= `HUEP_HIGH;
        serial_b_clear_to_send <= `HUEP_HIGH;
        serial_b_carrier_detect <= `HUEP_HIGH;
      end else begin
        serial_b_txrx_clock <= addrSync_reg[0];
        serial_b_rx_data <= addrSync_reg[1];
        serial_b_rxtx_clock <= addrSync_reg[2];
        serial_b_sync <= selN;
        serial_b_clear_to_send <= wrN;
        serial_b_carrier_detect <= rdN;
      end
    end
  end

  // shared output pins; in mode 0 serialAltSel picks serial B over clocked serial and dma end on irq and ready
  // status pins lag the core levels by one clock
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_driver_disable_n <= `HUEP_HIGH;
      host_irq <= `HUEP_LOW;
      host_tx_ready_n <= `HUEP_HIGH;
      host_rx_ready_n <= `HUEP_HIGH;
    end else begin
      if (hostOn) begin
        host_driver_disable_n <= ~readNow;
        host_irq <= coreIrqPending;
        // ready lines only signal in dma operation
        host_tx_ready_n <= ~(coreDmaMode & coreThrEmpty);
        host_rx_ready_n <= ~(coreDmaMode & coreRxAvail);
      end else begin
        host_driver_disable_n <= serial_b_tx_data;
        host_irq <= serialAltSel ? serial_b_terminal_ready_request :
          clocked_serial_tx;
        host_tx_ready_n <= serialAltSel ? serial_b_wait_request :
          clocked_serial_clock;
        host_rx_ready_n <= serialAltSel ? serial_b_request_to_send :
          dma1_transfer_end_n;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/huep_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the host pins and the core side of the port
module huep_port_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hostMode,
  input wire logic serialAltSel,
  input wire logic [7:0] host_data_bus_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic [7:0] portAOut,
  input wire logic [7:0] portADir,
  input wire logic serial_b_tx_data,
  input wire logic serial_b_terminal_ready_request,
  input wire logic serial_b_wait_request,
  input wire logic serial_b_request_to_send,
  input wire logic clocked_serial_tx,
  input wire logic clocked_serial_clock,
  input wire logic dma1_transfer_end_n,
  input wire logic host_select_n,
  input wire logic host_read_n,
  input wire logic [7:0] host_data_bus_oen_n,
  input wire logic host_driver_disable_n,
  input wire logic host_irq,
  input wire logic host_tx_ready_n,
  input wire logic host_rx_ready_n,
  input wire logic coreIrqPending,
  input wire logic coreDmaMode,
  input wire logic coreThrEmpty,
  input wire logic coreRxAvail,
  input wire logic coreRdPulse,
  input wire logic coreWrValid,
  input wire logic coreWrReady,
  input wire logic [2:0] coreWrAddr,
  input wire logic [7:0] coreWrData,
  input wire logic [7:0] port_a_pins,
  input wire logic serial_b_clear_to_send,
  input wire logic hostWrOverrun
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // pins pass two sync flops and a register: four samples suffice
  a_read_drive:
    assert property ((hostMode && !host_select_n && !host_read_n) [*4]
      |-> host_data_bus_oen_n == 8'h00) else $error("read not driven");
  a_bus_released:
    assert property ((hostMode && (host_select_n || host_read_n)) [*4]
      |-> host_data_bus_oen_n == 8'hFF) else $error("bus not released");
  a_disable_tracks:
    assert property (hostMode [*3]
      |-> host_driver_disable_n == host_data_bus_oen_n[0])
    else $error("driver disable off");
  a_irq_follows:
    assert property (hostMode && $past(hostMode) && $past(rstn)
      |-> host_irq == $past(coreIrqPending)) else $error("irq wrong");
  a_tx_ready:
    assert property (hostMode && $past(hostMode) && $past(rstn)
      |-> host_tx_ready_n == !($past(coreDmaMode) && $past(coreThrEmpty)))
    else $error("tx ready wrong");
  a_rx_ready:
    assert property (hostMode && $past(hostMode) && $past(rstn)
      |-> host_rx_ready_n == !($past(coreDmaMode) && $past(coreRxAvail)))
    else $error("rx ready wrong");
  a_pulse_once:
    assert property (coreRdPulse |-> host_data_bus_oen_n == 8'h00
      ##1 !coreRdPulse) else $error("read pulse wrong");
  a_beat_held:
    assert property (coreWrValid && !coreWrReady |=> coreWrValid
      && $stable(coreWrAddr) && $stable(coreWrData))
    else $error("write beat dropped");
  a_mode1_pins:
    assert property (hostMode [*3] |-> port_a_pins == 8'h00
      && serial_b_clear_to_send) else $error("shared pins wrong");
  a_overrun_clear:
    assert property (!hostMode [*2] |-> !hostWrOverrun)
    else $error("overrun kept");
  a_port_a_drive:
    assert property (!hostMode && !$past(hostMode) && $past(rstn)
      |-> host_data_bus_oen_n == ~$past(portADir)
      && host_data_bus_out == $past(portAOut))
    else $error("port a drive wrong");
  a_port_a_read:
    assert property ((!hostMode) [*4]
      |-> port_a_pins == $past(host_data_bus_in, 3))
    else $error("port a level wrong");
  a_drvdis_serial:
    assert property (!hostMode && !$past(hostMode) && $past(rstn)
      |-> host_driver_disable_n == $past(serial_b_tx_data))
    else $error("shared disable pin wrong");
  a_irq_shared:
    assert property (!hostMode && !$past(hostMode) && $past(rstn)
      |-> host_irq == ($past(serialAltSel) ?
      $past(serial_b_terminal_ready_request) : $past(clocked_serial_tx)))
    else $error("shared irq pin wrong");
  a_ready_shared:
    assert property (!hostMode && !$past(hostMode) && $past(rstn)
      |-> host_tx_ready_n == ($past(serialAltSel) ?
      $past(serial_b_wait_request) : $past(clocked_serial_clock))
      && host_rx_ready_n == ($past(serialAltSel) ?
      $past(serial_b_request_to_send) : $past(dma1_transfer_end_n)))
    else $error("shared ready pins wrong");
endmodule
bind huep_port huep_port_checker huep_port_checker_inst (.*);
`default_nettype wire

/* tb/huep_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// expansion bus host; all levels change on the falling edge
module huep_host_model (
  input wire logic clk,
  output logic host_select_n,
  output logic host_write_n,
  output logic host_read_n,
  output logic [2:0] host_reg_select,
  output logic [7:0] hostDrive
);
  // no pull on the bus, so idle shows the inverse of the last byte
  initial begin
    host_select_n = 1'h1;
    host_write_n = 1'h1;
    host_read_n = 1'h1;
    host_reg_select = 3'h0;
    hostDrive = 8'h00;
  end
  // four clocks per level, one above the port's minimum
  task automatic hold();
    repeat (4) @(negedge clk);
  endtask
  // write: address and data settle before the strobe pulse
  task automatic hostWrite(input logic [2:0] a, input logic [7:0] d);
    host_reg_select = a;
    hostDrive = d;
    host_select_n = 1'h0;
    hold();
    host_write_n = 1'h0;
    hold();
    host_write_n = 1'h1;
    hold();
    host_select_n = 1'h1;
    hostDrive = ~d;
    hold();
  endtask
  // read: strobe held long enough for the drive to appear
  task automatic hostRead(input logic [2:0] a);
    host_reg_select = a;
    host_select_n = 1'h0;
    hold();
    host_read_n = 1'h0;
    repeat (2) hold();
    host_read_n = 1'h1;
    hold();
    host_select_n = 1'h1;
    hold();
  endtask
  // raw pin levels, for the shared-pin checks
  task automatic setPins(input logic [5:0] v);
    {host_select_n, host_write_n, host_read_n, host_reg_select} = v;
  endtask
endmodule
`default_nettype wire

/* tb/huep_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module huep_port_bench;
  logic clk, rstn, hostMode, readyOn, coreRegWe;
  logic [2:0] coreRegAddr, coreWrAddr, coreRdAddr, host_reg_select;
  logic [7:0] coreRegData, coreWrData, host_data_bus_out, hostDrive;
  logic [7:0] host_data_bus_oen_n, port_a_pins, host_data_bus_in;
  logic [7:0] portAOut, portADir, img [8], d;
  logic host_select_n, host_write_n, host_read_n, host_driver_disable_n;
  logic host_irq, host_tx_ready_n, host_rx_ready_n, serial_b_txrx_clock;
  logic serial_b_rx_data, serial_b_rxtx_clock, serial_b_sync;
  logic serial_b_clear_to_send, serial_b_carrier_detect, serial_b_tx_data;
  logic serial_b_terminal_ready_request, serial_b_wait_request;
  logic serial_b_request_to_send, clocked_serial_tx, clocked_serial_clock;
  logic dma1_transfer_end_n, coreIrqPending, coreDmaMode, coreThrEmpty;
  logic coreRxAvail, coreWrValid, coreRdPulse, hostWrFull, hostWrOverrun;
  logic serialAltSel, coreWrReady;
  logic [31:0] rnd; // fresh random word each falling edge
  logic [31:0] r32; // one draw, narrowed on purpose
  logic [11:0] expQ [$]; // kind bit, address, data
  integer seed = 5859;
  integer numErrors = 0;
  integer checksDone = 0;
  integer i;
  // core levels and port A stay random throughout
  assign {serialAltSel, coreIrqPending, coreDmaMode, coreThrEmpty,
    coreRxAvail, serial_b_tx_data, serial_b_terminal_ready_request,
    serial_b_wait_request, serial_b_request_to_send, clocked_serial_tx,
    clocked_serial_clock, dma1_transfer_end_n, portAOut, portADir} = rnd[27:0];
  assign coreWrReady = readyOn & rnd[31]; // stalls even when draining
  // wire level: the port wins where it drives, else the host's value
  assign host_data_bus_in = (~host_data_bus_oen_n & host_data_bus_out)
    | (host_data_bus_oen_n & hostDrive);
  huep_port huep_port_inst (.*);
  huep_host_model huep_host_model_inst (.*);
  initial begin
    clk = 1'h0;
    rnd = 32'h0000_0000;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) rnd <= $random(seed);
  task summarize();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task checkFlag(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      numErrors++;
    end
  endtask
  // a result with nothing noted against it compares to unknown
  task checkBeat(input logic [11:0] got);
    logic [11:0] exp;
    exp = (expQ.size() != 0) ? expQ.pop_front() : 12'hXXX;
    checksDone++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      numErrors++;
    end
  endtask
  // pre-edge values: inputs only move on the falling edge
  always @(posedge clk) begin
    if (coreRdPulse)
      checkBeat({1'h1, coreRdAddr, host_data_bus_out});
    if (coreWrValid && coreWrReady)
      checkBeat({1'h0, coreWrAddr, coreWrData});
  end
  task waitEmpty();
    for (i = 0; i < 3000 && expQ.size() != 0; i++)
      @(negedge clk);
    if (expQ.size() != 0) begin
      numErrors++;
      summarize();
    end
  endtask
  initial begin
    #400000;
    numErrors++;
    summarize();
  end
  initial begin
    rstn = 1'h0;
    hostMode = 1'h1;
    readyOn = 1'h0;
    coreRegWe = 1'h0;
    coreRegAddr = 3'h0;
    coreRegData = 8'h00;
    repeat (10) @(negedge clk);
    rstn = 1'h1;
    // fill the whole image before any host read
    for (i = 0; i < 8; i++) begin
      r32 = $random(seed);
      img[i] = r32[7:0];
      coreRegWe = 1'h1;
      coreRegAddr = i[2:0];
      coreRegData = img[i];
      @(negedge clk);
    end
    coreRegWe = 1'h0;
    repeat (4) @(negedge clk);
    for (i = 0; i < 8; i++) begin
      expQ.push_back({1'h1, i[2:0], img[i]});
      huep_host_model_inst.hostRead(i[2:0]);
    end
    // core stalled: eight in the queue plus one staged, rest dropped
    for (i = 0; i < 11; i++) begin
      r32 = $random(seed);
      d = r32[7:0];
      if (i < 9)
        expQ.push_back({1'h0, i[2:0], d});
      huep_host_model_inst.hostWrite(i[2:0], d);
    end
    checkFlag({7'h00, hostWrFull}, 8'h01);
    checkFlag({7'h00, hostWrOverrun}, 8'h01);
    readyOn = 1'h1;
    waitEmpty();
    // mode 0: strobes ignored, host pins fed to serial B
    hostMode = 1'h0;
    huep_host_model_inst.hostWrite(3'h5, 8'hA5);
    for (i = 0; i < 8; i++) begin
      r32 = $random(seed);
      d = r32[7:0];
      huep_host_model_inst.setPins(d[5:0]);
      repeat (4) @(negedge clk);
      checkFlag({2'h0, serial_b_rxtx_clock, serial_b_rx_data,
        serial_b_txrx_clock, serial_b_sync, serial_b_clear_to_send,
        serial_b_carrier_detect}, {2'h0, d[2:0], d[5:3]});
    end
    huep_host_model_inst.setPins(6'h38);
    repeat (4) @(negedge clk);
    checkFlag({7'h00, hostWrOverrun}, 8'h00);
    hostMode = 1'h1;
    repeat (4) @(negedge clk);
    // mid-run reset: image survives, bus and disable go idle
    rstn = 1'h0;
    repeat (2) @(negedge clk);
    rstn = 1'h1;
    checkFlag(host_data_bus_oen_n, 8'hFF);
    checkFlag({7'h00, host_driver_disable_n}, 8'h01);
    repeat (2) @(negedge clk);
    expQ.push_back({1'h1, 3'h7, img[7]});
    huep_host_model_inst.hostRead(3'h7);
    waitEmpty();
    summarize();
  end
endmodule
`default_nettype wire
